// ==== src/pspc_pkg.sv ====
// Constants, types and register map of the pump staging and slow-fill block.
// Assumes one 50 MHz clock; pressures and speeds are unsigned 16-bit counts.
package pspc_pkg;

   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_PERIOD_S = 1;
   localparam int SEC_CYCLES = TICK_PERIOD_S * 1000000000 / CLK_PERIOD_NS;
   localparam logic [5:0] SECS_PER_MIN = 6'h3C;
   localparam logic [1:0] MAX_AUX = 2'h2;

   // Register byte offsets
   localparam logic [7:0] A_MODE = 8'h00;
   localparam logic [7:0] A_TARGET = 8'h04;
   localparam logic [7:0] A_FILL = 8'h08;
   localparam logic [7:0] A_FILL_TIME = 8'h0C;
   localparam logic [7:0] A_ENGAGE = 8'h10;
   localparam logic [7:0] A_RELEASE = 8'h14;
   localparam logic [7:0] A_RISE = 8'h18;
   localparam logic [7:0] A_LIMITS = 8'h1C;
   localparam logic [7:0] A_DELAYS = 8'h20;
   localparam logic [7:0] A_HOLDS = 8'h24;
   localparam logic [7:0] A_STATUS = 8'h28;

   // Field positions
   localparam int MODE_AUX_LSB = 0;
   localparam int MODE_CP_BIT = 2;
   localparam int HI_LSB = 16;
   localparam int STAT_RELAY_LSB = 0;
   localparam int STAT_STATE_LSB = 2;
   localparam int STAT_FILL_BIT = 4;

   // Reset values
   localparam logic [15:0] RST_TARGET = 16'h0032;
   localparam logic [15:0] RST_MIN_F = 16'h001E;
   localparam logic [15:0] RST_MAX_F = 16'h003C;
   localparam logic [15:0] RST_OFFSET = 16'h0005;
   localparam logic [15:0] RST_TIME = 16'h000A;

   typedef enum logic [1:0] {
      PSPC_RUN_OFF = 2'b00,
      PSPC_RUN_AUTO = 2'b01,
      PSPC_RUN_MANUAL = 2'b10,
      PSPC_RUN_BAD = 2'b11
   } pspc_run_t;

   typedef enum logic [1:0] {
      PSPC_CP_NORMAL = 2'b00,
      PSPC_ENGAGE_HOLD = 2'b01,
      PSPC_RELEASE_HOLD = 2'b10
   } pspc_ll_t;

   typedef struct packed {
      logic [1:0] aux_count;
      logic cp_sel;
      logic [15:0] target;
      logic [15:0] slow_fill_exit_pressure;
      logic [15:0] slow_fill_speed_cap;
      logic [7:0] fill_minutes;
      logic [15:0] engage_pressure_offset;
      logic [15:0] engage_speed_drop;
      logic [15:0] release_pressure_offset;
      logic [15:0] release_speed_window;
      logic [15:0] release_speed_rise;
      logic [15:0] min_speed;
      logic [15:0] max_speed;
      logic [15:0] engage_delay;
      logic [15:0] release_delay;
      logic [15:0] engage_hold_time;
      logic [15:0] release_hold_time;
   } pspc_cfg_t;

   typedef struct packed {
      pspc_run_t run;
      logic [15:0] pressure;
      logic [15:0] loop_speed;
      logic [1:0] relay_func;
   } pspc_plant_t;

   typedef struct packed {
      pspc_cfg_t cfg;
      logic [31:0] hrdata;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] presc;
      logic fill_act;
      logic [5:0] fill_sec;
      logic [7:0] fill_min;
      logic prev_run;
      pspc_ll_t st;
      logic [1:0] aux_on;
      logic [15:0] eng_tmr;
      logic [15:0] rel_tmr;
      logic [15:0] hold_tmr;
      logic [15:0] speed;
      logic [1:0] relay;
   } pspc_state_t;

endpackage

// ==== src/pspc_ctrl.sv ====
// Slow-fill and auxiliary pump staging controller with an AHB-Lite slave.
// Pressure, run mode, loop speed and relay requests come from same-clock
// logic; relay outputs drive external starters.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module pspc_ctrl #(
   parameter int SEC_CYCLES = pspc_pkg::SEC_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire pspc_pkg::pspc_plant_t plant,
   output logic [15:0] speed_cmd,
   output logic aux_relay_first_contact,
   output logic aux_relay_second_contact,
   output logic slow_fill_active
);

   pspc_pkg::pspc_state_t s_ff;
   pspc_pkg::pspc_state_t nxt_s;
   logic tick;
   logic run_now;
   logic ll_sel;
   logic ll_on;
   logic [1:0] limit;
   logic low_p;
   logic high_p;
   logic in_win;
   logic stage_go;
   logic release_go;
   logic [15:0] hold_need;
   logic [15:0] spd;
   logic [31:0] status;
   logic addr_ok;

   function automatic logic [15:0] sat_sub(input logic [15:0] a,
                                           input logic [15:0] b);
      sat_sub = (a > b) ? a - b : 16'h0000;
   endfunction

   function automatic logic [15:0] sat_add(input logic [15:0] a,
                                           input logic [15:0] b);
      logic [16:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      sat_add = sum[16] ? 16'hFFFF : sum[15:0];
   endfunction

   function automatic logic [31:0] rd(input logic [7:0] a,
                                      input pspc_pkg::pspc_cfg_t c,
                                      input logic [31:0] stat);
      unique case (a)
         pspc_pkg::A_MODE: rd = {29'h0, c.cp_sel, c.aux_count};
         pspc_pkg::A_TARGET: rd = {16'h0000, c.target};
         pspc_pkg::A_FILL: rd = {c.slow_fill_speed_cap,
                                 c.slow_fill_exit_pressure};
         pspc_pkg::A_FILL_TIME: rd = {24'h0, c.fill_minutes};
         pspc_pkg::A_ENGAGE: rd = {c.engage_speed_drop,
                                   c.engage_pressure_offset};
         pspc_pkg::A_RELEASE: rd = {c.release_speed_window,
                                    c.release_pressure_offset};
         pspc_pkg::A_RISE: rd = {16'h0000, c.release_speed_rise};
         pspc_pkg::A_LIMITS: rd = {c.max_speed, c.min_speed};
         pspc_pkg::A_DELAYS: rd = {c.release_delay, c.engage_delay};
         pspc_pkg::A_HOLDS: rd = {c.release_hold_time, c.engage_hold_time};
         pspc_pkg::A_STATUS: rd = stat;
         default: rd = 32'h0000_0000;
      endcase
   endfunction

   // Plain word registers only, so the slave never stretches a transfer
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_ff.hrdata;
   assign speed_cmd = s_ff.speed;
   assign aux_relay_first_contact = s_ff.relay[0];
   assign aux_relay_second_contact = s_ff.relay[1];
   assign slow_fill_active = s_ff.fill_act;

   always_comb begin
      nxt_s = s_ff;
      addr_ok = (haddr[31:8] == 24'h00_0000);
      status = 32'h0000_0000;
      status[pspc_pkg::STAT_RELAY_LSB +: 2] = s_ff.relay;
      status[pspc_pkg::STAT_STATE_LSB +: 2] = s_ff.st;
      status[pspc_pkg::STAT_FILL_BIT] = s_ff.fill_act;
      status[pspc_pkg::HI_LSB +: 16] = s_ff.speed;

      // Bus data phase of a write
      if (s_ff.wr_pend) begin
         unique case (s_ff.wr_addr)
            pspc_pkg::A_MODE: begin
               nxt_s.cfg.aux_count = hwdata[pspc_pkg::MODE_AUX_LSB +: 2];
               nxt_s.cfg.cp_sel = hwdata[pspc_pkg::MODE_CP_BIT];
            end
            pspc_pkg::A_TARGET: nxt_s.cfg.target = hwdata[15:0];
            pspc_pkg::A_FILL: begin
               nxt_s.cfg.slow_fill_exit_pressure = hwdata[15:0];
               nxt_s.cfg.slow_fill_speed_cap = hwdata[31:16];
            end
            pspc_pkg::A_FILL_TIME: nxt_s.cfg.fill_minutes = hwdata[7:0];
            pspc_pkg::A_ENGAGE: begin
               nxt_s.cfg.engage_pressure_offset = hwdata[15:0];
               nxt_s.cfg.engage_speed_drop = hwdata[31:16];
            end
            pspc_pkg::A_RELEASE: begin
               nxt_s.cfg.release_pressure_offset = hwdata[15:0];
               nxt_s.cfg.release_speed_window = hwdata[31:16];
            end
            pspc_pkg::A_RISE: nxt_s.cfg.release_speed_rise = hwdata[15:0];
            pspc_pkg::A_LIMITS: begin
               nxt_s.cfg.min_speed = hwdata[15:0];
               nxt_s.cfg.max_speed = hwdata[31:16];
            end
            pspc_pkg::A_DELAYS: begin
               nxt_s.cfg.engage_delay = hwdata[15:0];
               nxt_s.cfg.release_delay = hwdata[31:16];
            end
            pspc_pkg::A_HOLDS: begin
               nxt_s.cfg.engage_hold_time = hwdata[15:0];
               nxt_s.cfg.release_hold_time = hwdata[31:16];
            end
            default: ;
         endcase
      end

      // Bus address phase
      nxt_s.wr_pend = hsel && htrans[1] && hready && hwrite && addr_ok;
      nxt_s.wr_addr = haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
         nxt_s.hrdata = addr_ok ? rd(haddr[7:0], s_ff.cfg, status)
                                : 32'h0000_0000;
      end

      // One-second time base
      tick = (s_ff.presc == 32'(SEC_CYCLES - 1));
      nxt_s.presc = tick ? 32'h0000_0000 : s_ff.presc + 32'h0000_0001;

      run_now = (plant.run == pspc_pkg::PSPC_RUN_AUTO) ||
                (plant.run == pspc_pkg::PSPC_RUN_MANUAL);
      nxt_s.prev_run = run_now;

      // Slow fill
      if (s_ff.cfg.fill_minutes == 8'h00 || !run_now ||
          plant.pressure > s_ff.cfg.slow_fill_exit_pressure) begin
         nxt_s.fill_act = 1'b0;
      end else if (!s_ff.prev_run) begin
         nxt_s.fill_act = 1'b1;
         nxt_s.fill_sec = 6'h00;
         nxt_s.fill_min = 8'h00;
      end else if (s_ff.fill_act && tick) begin
         if (s_ff.fill_sec == pspc_pkg::SECS_PER_MIN - 6'h01) begin
            nxt_s.fill_sec = 6'h00;
            nxt_s.fill_min = s_ff.fill_min + 8'h01;
            if (s_ff.fill_min + 8'h01 >= s_ff.cfg.fill_minutes) begin
               nxt_s.fill_act = 1'b0;
            end
         end else begin
            nxt_s.fill_sec = s_ff.fill_sec + 6'h01;
         end
      end

      // Lead/lag needs constant-pressure configuration and a pump count
      ll_sel = s_ff.cfg.cp_sel && (s_ff.cfg.aux_count != 2'h0);
      ll_on = ll_sel && run_now;
      limit = (s_ff.cfg.aux_count > pspc_pkg::MAX_AUX) ? pspc_pkg::MAX_AUX
                                                      : s_ff.cfg.aux_count;
      low_p = plant.pressure <= sat_sub(s_ff.cfg.target,
                                        s_ff.cfg.engage_pressure_offset);
      high_p = plant.pressure >= sat_add(s_ff.cfg.target,
                                         s_ff.cfg.release_pressure_offset);
      in_win = (s_ff.speed >= s_ff.cfg.min_speed) &&
               (s_ff.speed <= sat_add(s_ff.cfg.min_speed,
                                      s_ff.cfg.release_speed_window));

      // Delay timers restart whenever their pressure condition lapses
      if (!ll_on || !low_p || s_ff.st != pspc_pkg::PSPC_CP_NORMAL) begin
         nxt_s.eng_tmr = 16'h0000;
      end else if (tick && s_ff.eng_tmr != 16'hFFFF) begin
         nxt_s.eng_tmr = s_ff.eng_tmr + 16'h0001;
      end
      if (!ll_on || !high_p || s_ff.st != pspc_pkg::PSPC_CP_NORMAL) begin
         nxt_s.rel_tmr = 16'h0000;
      end else if (tick && s_ff.rel_tmr != 16'hFFFF) begin
         nxt_s.rel_tmr = s_ff.rel_tmr + 16'h0001;
      end

      stage_go = ll_on && (s_ff.st == pspc_pkg::PSPC_CP_NORMAL) && low_p &&
                 (s_ff.eng_tmr >= s_ff.cfg.engage_delay) &&
                 (s_ff.aux_on < limit);
      release_go = ll_on && (s_ff.st == pspc_pkg::PSPC_CP_NORMAL) &&
                   !stage_go && high_p && in_win &&
                   (s_ff.rel_tmr >= s_ff.cfg.release_delay) &&
                   (s_ff.aux_on != 2'h0);
      hold_need = (s_ff.st == pspc_pkg::PSPC_ENGAGE_HOLD) ?
                  s_ff.cfg.engage_hold_time : s_ff.cfg.release_hold_time;

      if (!ll_on) begin
         nxt_s.st = pspc_pkg::PSPC_CP_NORMAL;
         nxt_s.aux_on = 2'h0;
         nxt_s.hold_tmr = 16'h0000;
      end else begin
         unique case (s_ff.st)
            pspc_pkg::PSPC_CP_NORMAL: begin
               nxt_s.hold_tmr = 16'h0000;
               if (stage_go) begin
                  nxt_s.aux_on = s_ff.aux_on + 2'h1;
                  nxt_s.st = pspc_pkg::PSPC_ENGAGE_HOLD;
               end else if (release_go) begin
                  nxt_s.aux_on = s_ff.aux_on - 2'h1;
                  nxt_s.st = pspc_pkg::PSPC_RELEASE_HOLD;
               end else if (s_ff.aux_on > limit) begin
                  nxt_s.aux_on = limit;
               end
            end
            pspc_pkg::PSPC_ENGAGE_HOLD,
            pspc_pkg::PSPC_RELEASE_HOLD: begin
               if (s_ff.hold_tmr >= hold_need) begin
                  nxt_s.st = pspc_pkg::PSPC_CP_NORMAL;
                  nxt_s.hold_tmr = 16'h0000;
               end else if (tick) begin
                  nxt_s.hold_tmr = s_ff.hold_tmr + 16'h0001;
               end
            end
            default: nxt_s.st = pspc_pkg::PSPC_CP_NORMAL;
         endcase
      end

      // Relays follow the pump count; other relay duties yield to lead/lag
      if (ll_sel) begin
         nxt_s.relay = {nxt_s.aux_on >= 2'h2, nxt_s.aux_on >= 2'h1};
      end else begin
         nxt_s.relay = plant.relay_func;
      end

      // Speed follows the registered state, so it moves one cycle after
      // the relay and the contact always leads the speed step
      unique case (s_ff.st)
         pspc_pkg::PSPC_ENGAGE_HOLD:
            spd = sat_sub(s_ff.cfg.max_speed,
                          s_ff.cfg.engage_speed_drop);
         pspc_pkg::PSPC_RELEASE_HOLD:
            spd = sat_add(s_ff.cfg.min_speed,
                          s_ff.cfg.release_speed_rise);
         default: spd = plant.loop_speed;
      endcase
      if (!run_now) begin
         spd = 16'h0000;
      end else if (nxt_s.fill_act && spd > s_ff.cfg.slow_fill_speed_cap) begin
         spd = s_ff.cfg.slow_fill_speed_cap;
      end
      nxt_s.speed = spd;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_ff <= '0;
         s_ff.cfg.target <= pspc_pkg::RST_TARGET;
         s_ff.cfg.min_speed <= pspc_pkg::RST_MIN_F;
         s_ff.cfg.max_speed <= pspc_pkg::RST_MAX_F;
         s_ff.cfg.engage_pressure_offset <= pspc_pkg::RST_OFFSET;
         s_ff.cfg.release_pressure_offset <= pspc_pkg::RST_OFFSET;
         s_ff.cfg.engage_delay <= pspc_pkg::RST_TIME;
         s_ff.cfg.release_delay <= pspc_pkg::RST_TIME;
         s_ff.cfg.engage_hold_time <= pspc_pkg::RST_TIME;
         s_ff.cfg.release_hold_time <= pspc_pkg::RST_TIME;
      end else if (ce) begin
         s_ff <= nxt_s;
      end
   end

   a_fill_zero_off: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && s_ff.cfg.fill_minutes == 8'h00) |=> !s_ff.fill_act)
      else $error("slow fill active with zero duration");

   a_fill_cap_held: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && nxt_s.fill_act) |->
      nxt_s.speed <= s_ff.cfg.slow_fill_speed_cap)
      else $error("speed above slow-fill cap");

   a_fill_exit_now: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && s_ff.fill_act &&
       plant.pressure > s_ff.cfg.slow_fill_exit_pressure) |=>
      !s_ff.fill_act)
      else $error("slow fill not ended above exit pressure");

   a_fill_start_run: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && !s_ff.prev_run && run_now && s_ff.cfg.fill_minutes != 8'h00 &&
       plant.pressure <= s_ff.cfg.slow_fill_exit_pressure) |=>
      s_ff.fill_act)
      else $error("slow fill not started on run");

   a_relay_order: assert property (
      @(posedge clock) disable iff (!rst_b)
      s_ff.cfg.cp_sel && s_ff.cfg.aux_count != 2'h0 && ce |=>
      !(s_ff.relay[1] && !s_ff.relay[0]))
      else $error("second relay closed before first");

   a_stage_guard: assert property (
      @(posedge clock) disable iff (!rst_b)
      stage_go |-> low_p && s_ff.eng_tmr >= s_ff.cfg.engage_delay)
      else $error("engage without pressure and delay");

   a_stage_step: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && stage_go) |=>
      s_ff.aux_on == $past(s_ff.aux_on) + 2'h1 &&
      s_ff.st == pspc_pkg::PSPC_ENGAGE_HOLD)
      else $error("engage did not add exactly one pump");

   a_release_guard: assert property (
      @(posedge clock) disable iff (!rst_b)
      release_go |-> high_p && in_win &&
      s_ff.rel_tmr >= s_ff.cfg.release_delay)
      else $error("release without all three conditions");

   a_release_step: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && release_go) |=>
      s_ff.aux_on == $past(s_ff.aux_on) - 2'h1 &&
      s_ff.st == pspc_pkg::PSPC_RELEASE_HOLD)
      else $error("release did not drop exactly one pump");

   a_engage_speed: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && run_now && s_ff.st == pspc_pkg::PSPC_ENGAGE_HOLD &&
       !nxt_s.fill_act) |->
      nxt_s.speed == sat_sub(s_ff.cfg.max_speed,
                             s_ff.cfg.engage_speed_drop))
      else $error("engage hold speed wrong");

   a_release_speed: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && run_now && s_ff.st == pspc_pkg::PSPC_RELEASE_HOLD &&
       !nxt_s.fill_act) |->
      nxt_s.speed == sat_add(s_ff.cfg.min_speed,
                             s_ff.cfg.release_speed_rise))
      else $error("release hold speed wrong");

   a_hold_count_kept: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && ll_on && s_ff.st != pspc_pkg::PSPC_CP_NORMAL) |=>
      s_ff.aux_on == $past(s_ff.aux_on))
      else $error("pump count moved during a hold");

   a_aux_count_max: assert property (
      @(posedge clock) disable iff (!rst_b)
      s_ff.aux_on <= pspc_pkg::MAX_AUX)
      else $error("more aux pumps on than allowed");

   a_relay_follow_func: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && !ll_sel) |=>
      {aux_relay_second_contact, aux_relay_first_contact} ==
      $past(plant.relay_func))
      else $error("relays do not follow their own duty");

   a_off_speed_zero: assert property (
      @(posedge clock) disable iff (!rst_b)
      (ce && !run_now) |=> speed_cmd == 16'h0000)
      else $error("speed command not zero while off");

endmodule

`default_nettype wire

// ==== test/pspc_plant_model.sv ====
// Far-side stand-in: pressure source, speed loop and aux pump starters.
// Assumes the bench sets the demanded run mode, pressure and loop speed.
`timescale 1ns/100ps
`default_nettype none

module pspc_plant_model (
   input wire logic clock,
   input wire pspc_pkg::pspc_run_t run_req,
   input wire logic [15:0] pressure_req,
   input wire logic [15:0] speed_req,
   input wire logic [1:0] func_req,
   input wire logic first_closed,
   input wire logic second_closed,
   output var pspc_pkg::pspc_plant_t plant,
   output logic [1:0] pumps_running
);
   // Starters pull in one cycle after their contact closes
   always_ff @(posedge clock) begin
      pumps_running <= 2'(first_closed) + 2'(second_closed);
   end

   always_comb begin
      plant.run = run_req;
      plant.pressure = pressure_req;
      plant.loop_speed = speed_req;
      plant.relay_func = func_req;
   end
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the slow-fill and aux pump staging controller.
// Assumes the controller and plant model files are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic ce = 1'b1;
   logic hsel = 1'b1;
   logic [2:0] hsize = 3'h2;
   pspc_pkg::pspc_run_t run_req = pspc_pkg::PSPC_RUN_OFF;
   logic [15:0] pres = 16'h0032;
   logic [15:0] loop = 16'h0028;
   logic [1:0] func = 2'h0;
   pspc_pkg::pspc_plant_t plant;
   logic [15:0] speed_cmd;
   logic first;
   logic second;
   logic fill;
   logic [1:0] pumps_running;
   integer seed = 32'hDCA6;
   int miscompares = 0;
   int total_checks = 0;
   logic [31:0] rd_q[$];
   logic [2:0] ev_q[$];
   logic rd_pend = 1'b0;
   logic [2:0] ev;
   logic [2:0] ev_last = 3'h0;

   always #10 clock = ~clock;

   pspc_ctrl #(.SEC_CYCLES(20)) pspc_ctrl_inst (
      .clock(clock), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .plant(plant), .speed_cmd(speed_cmd),
      .aux_relay_first_contact(first), .aux_relay_second_contact(second),
      .slow_fill_active(fill));

   pspc_plant_model pspc_plant_model_inst (
      .clock(clock), .run_req(run_req), .pressure_req(pres),
      .speed_req(loop), .func_req(func), .first_closed(first),
      .second_closed(second), .plant(plant),
      .pumps_running(pumps_running));

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
      @(posedge clock);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
   endtask

   task automatic wr(logic [31:0] a, logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(logic [31:0] a, logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic wait_relays(logic [1:0] want);
      for (int i = 0; i < 400; i++) begin
         if ({second, first} === want) break;
         cyc(1);
      end
      check("relay wait", {second, first}, want);
   endtask

   // Results are judged where they appear, against the oldest note
   always @(posedge clock) begin
      if (rd_pend) begin
         check("read data", hrdata, rd_q.size() ? rd_q.pop_front() : 32'h0);
      end
      rd_pend <= rst_b & ce & hsel & htrans[1] & ~hwrite & hreadyout;
      ev = {fill, second, first};
      if (rst_b && ev !== ev_last) begin
         check("fill and relays", ev, ev_q.size() ? ev_q.pop_front() : 3'h7);
      end
      ev_last <= ev;
   end

   initial begin
      #400000;
      miscompares++;
      final_report();
   end

   initial begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      rd(pspc_pkg::A_TARGET, {16'h0, pspc_pkg::RST_TARGET});
      rd(pspc_pkg::A_LIMITS, {pspc_pkg::RST_MAX_F, pspc_pkg::RST_MIN_F});
      rd(pspc_pkg::A_MODE, 32'h0);
      rd(8'h40, 32'h0);
      rd(32'h0000_0104, 32'h0);
      hsel <= 1'b0;
      wr(pspc_pkg::A_TARGET, 32'h0000_0020);
      hsel <= 1'b1;
      rd(pspc_pkg::A_TARGET, {16'h0, pspc_pkg::RST_TARGET});
      check("speed off", speed_cmd, 16'h0);
      // Exit pressure kept below the target
      wr(pspc_pkg::A_FILL, 32'h00140028);
      wr(pspc_pkg::A_FILL_TIME, 32'h1);
      pres <= 16'h0010;
      loop <= 16'h0015 + 16'($random(seed) & 32'hFF);
      ev_q.push_back(3'h4);
      run_req <= pspc_pkg::PSPC_RUN_AUTO;
      cyc(4);
      check("capped speed", speed_cmd, 16'h0014);
      ev_q.push_back(3'h0);
      pres <= 16'h0029;
      cyc(4);
      check("speed after fill", speed_cmd, loop);
      run_req <= pspc_pkg::PSPC_RUN_OFF;
      pres <= 16'h0010;
      cyc(3);
      ev_q.push_back(3'h4);
      run_req <= pspc_pkg::PSPC_RUN_MANUAL;
      cyc(1100);
      check("fill running", fill, 1'b1);
      ev_q.push_back(3'h0);
      cyc(200);
      check("fill timed out", fill, 1'b0);
      run_req <= pspc_pkg::PSPC_RUN_OFF;
      wr(pspc_pkg::A_FILL_TIME, 32'h0);
      run_req <= pspc_pkg::PSPC_RUN_AUTO;
      cyc(5);
      check("fill disabled", fill, 1'b0);
      ev_q.push_back(3'h1);
      func <= 2'h1;
      pres <= 16'h0032;
      loop <= 16'h0028;
      wr(pspc_pkg::A_ENGAGE, 32'h00050005);
      wr(pspc_pkg::A_RELEASE, 32'h00050005);
      wr(pspc_pkg::A_RISE, 32'h5);
      wr(pspc_pkg::A_DELAYS, 32'h00020002);
      wr(pspc_pkg::A_HOLDS, 32'h00030003);
      wr(pspc_pkg::A_MODE, 32'h3);
      cyc(2);
      check("no lead/lag without cp", {second, first}, 2'h1);
      ev_q.push_back(3'h0);
      // Lead/lag only with the constant-pressure selection
      wr(pspc_pkg::A_MODE, 32'h7);
      func <= 2'h2 | 2'($random(seed));
      cyc(5);
      check("relay functions ignored", {second, first}, 2'h0);
      ev_q.push_back(3'h1);
      pres <= 16'h002D;
      cyc(15);
      check("engage delay", first, 1'b0);
      wait_relays(2'h1);
      cyc(1);
      check("engage speed", speed_cmd, 16'h0037);
      cyc(35);
      check("engage hold", speed_cmd, 16'h0037);
      rd(pspc_pkg::A_STATUS, 32'h0037_0005);
      ev_q.push_back(3'h3);
      wait_relays(2'h3);
      cyc(90);
      check("speed resumed", speed_cmd, loop);
      check("two pumps at most", pumps_running, 2'h2);
      pres <= 16'h0037;
      loop <= 16'h0030;
      cyc(100);
      check("outside window", {second, first}, 2'h3);
      ev_q.push_back(3'h1);
      loop <= 16'h0020;
      wait_relays(2'h1);
      cyc(1);
      check("release speed", speed_cmd, 16'h0023);
      ev_q.push_back(3'h0);
      wait_relays(2'h0);
      cyc(1);
      check("second release speed", speed_cmd, 16'h0023);
      cyc(90);
      check("speed after hold", speed_cmd, loop);
      ce <= 1'b0;
      loop <= 16'h0025;
      cyc(5);
      check("frozen speed", speed_cmd, 16'h0020);
      ce <= 1'b1;
      cyc(2);
      check("speed after freeze", speed_cmd, 16'h0025);
      check("pending notes", ev_q.size() + rd_q.size(), 32'h0);
      final_report();
   end
endmodule

`default_nettype wire
